// *** dv/hopm_checker.sv ***
// Concurrent assertions on the path monitor ports.
module hopm_checker (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // Register port
   input wire logic [7:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   // Frame overhead and trace
   input wire logic        frame_poh_valid,
   input wire logic [7:0]  poh_c2,
   input wire logic [7:0]  poh_g1,
   input wire logic        trace_msg_valid,
   input wire logic        trace_msg_same,
   // Alarms
   input wire logic        trace_mismatch_alarm,
   input wire logic        trace_crc_error_alarm,
   input wire logic        trace_unstable_alarm,
   input wire logic        label_mismatch_alarm,
   input wire logic        unequipped_alarm,
   input wire logic        path_ais_generated_status
);
   logic [15:0] cfg_reg;
   logic        cause;
   logic [7:0]  c2_seen;
   logic [3:0]  g1_seen;
   // ==========================================================================
   // Shadow of the second configuration register, so AIS causes can be judged.
   assign cause = cfg_reg[5] | cfg_reg[4] & label_mismatch_alarm
                | cfg_reg[3] & unequipped_alarm | cfg_reg[2] & trace_mismatch_alarm;
   always_ff @(posedge clk) begin
      if (rst) cfg_reg <= 16'h0200;
      else if (reg_wr && reg_addr == 8'hA5) cfg_reg <= reg_wdata & 16'h3F3C;
   end
   // Last overhead seen, so a readback at any distance from its frame can be judged.
   always_ff @(posedge clk) begin
      if (frame_poh_valid) begin
         c2_seen <= poh_c2;
         g1_seen <= poh_g1[3:0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ==========================================================================
   // Assertions
   AST_C2_READ:
      assert property (reg_rd && reg_addr == 8'hA7
         |=> reg_rdata == {8'h00, $past(c2_seen)}) else $error("label readback wrong");
   AST_G1_READ:
      assert property (reg_rd && reg_addr == 8'hA8
         |=> reg_rdata == {12'h000, $past(g1_seen)}) else $error("g1 readback wrong");
   AST_UNEQ:
      assert property (frame_poh_valid ##1 !frame_poh_valid
         |=> unequipped_alarm == ($past(poh_c2, 2) == 8'h00)) else $error("unequipped wrong");
   AST_FORCE:
      assert property (cfg_reg[5] [*3] |-> path_ais_generated_status) else $error("no forced ais");
   AST_NO_CAUSE:
      assert property (!cause [*3] |-> !path_ais_generated_status) else $error("ais without cause");
   AST_AIS_SLM:
      assert property ((cfg_reg[4] && label_mismatch_alarm) [*3] |-> path_ais_generated_status)
         else $error("no ais on label mismatch");
   AST_AIS_UNEQ:
      assert property ((cfg_reg[3] && unequipped_alarm) [*3] |-> path_ais_generated_status)
         else $error("no ais on unequipped");
   AST_AIS_TIM:
      assert property ((cfg_reg[2] && trace_mismatch_alarm) [*3] |-> path_ais_generated_status)
         else $error("no ais on trace mismatch");
   AST_FORCE_TIM:
      assert property ((cfg_reg[12] && trace_unstable_alarm) [*2] |-> trace_mismatch_alarm)
         else $error("unstable did not force mismatch");
   AST_CRC_MASK:
      assert property ((cfg_reg[13] && !cfg_reg[12] && trace_crc_error_alarm) [*2]
         |-> !trace_mismatch_alarm) else $error("crc error did not mask mismatch");
   AST_STABLE:
      assert property ($fell(trace_unstable_alarm) |-> $past(trace_msg_valid && trace_msg_same, 2)
         || $past(reg_wr, 2) || $past(reg_wr, 3)) else $error("unstable cleared without message");
   COV_UNEQ_AIS: cover property (cfg_reg[3] && unequipped_alarm && path_ais_generated_status);
   COV_STABLE: cover property ($fell(trace_unstable_alarm));
   COV_CNT_READ: cover property (reg_rd && reg_addr == 8'hA9);
endmodule

bind hopm_top hopm_checker u_chk (.*);

// *** dv/hopm_far_end.sv ***
// Far-end path terminating equipment model: frame overhead and trace messages.
module hopm_far_end (
   // Clock
   input  wire logic  clk,
   // Frame overhead
   output logic       frame_poh_valid = 1'b0,
   output logic [7:0] poh_c2 = 8'h00,
   output logic [7:0] poh_g1 = 8'h00,
   output logic [3:0] b3_error_bits = 4'h0,
   // Trace messages
   output logic       trace_msg_valid = 1'b0,
   output logic       trace_msg_same = 1'b0,
   output logic       trace_msg_match = 1'b0,
   output logic       trace_msg_crc_ok = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   // Overhead is only meaningful with its pulse, so it is inverted afterwards.
   task automatic frame(input logic [7:0] c2, input logic [7:0] g1, input logic [3:0] b3);
      @(posedge clk);
      frame_poh_valid <= 1'b1;
      poh_c2 <= c2;
      poh_g1 <= g1;
      b3_error_bits <= b3;
      @(posedge clk);
      frame_poh_valid <= 1'b0;
      poh_c2 <= ~c2;
      poh_g1 <= ~g1;
      b3_error_bits <= ~b3;
      repeat (3) @(negedge clk);
   endtask
   task automatic msg(input logic same, input logic match, input logic crc_ok);
      @(posedge clk);
      trace_msg_valid <= 1'b1;
      trace_msg_same <= same;
      trace_msg_match <= match;
      trace_msg_crc_ok <= crc_ok;
      @(posedge clk);
      trace_msg_valid <= 1'b0;
      trace_msg_same <= ~same;
      trace_msg_match <= ~match;
      trace_msg_crc_ok <= ~crc_ok;
      repeat (3) @(negedge clk);
   endtask
endmodule

// *** dv/tb_hopm_top.sv ***
// Self-checking testbench for the path monitor.
module tb_hopm_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic        frame_poh_valid, trace_msg_valid, trace_msg_same, trace_msg_match;
   logic        trace_msg_crc_ok, trace_mismatch_alarm, trace_crc_error_alarm;
   logic        trace_unstable_alarm, label_mismatch_alarm, unequipped_alarm;
   logic        path_ais_generated_status, irq;
   logic [7:0]  poh_c2, poh_g1;
   logic [3:0]  b3_error_bits;
   logic [15:0] cfgs [5] = '{16'h0704, 16'h0E04, 16'h0404, 16'h0804, 16'h0204};
   int          error_cnt = 0;
   int          comparisons = 0;
   int          cyc = 0;
   hopm_top dut (.*);
   hopm_far_end fe (.*);
   always #50 clk = ~clk;
   // ==========================================================================
   // Tasks
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk1(input string n, input logic e, input logic g);
      chk(n, {15'h0000, e}, {15'h0000, g});
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      repeat (2) @(negedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      chk($sformatf("reg %h", a), e, reg_rdata);
   endtask
   task automatic tally_and_finish();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // The whole sequence needs well under 3000 cycles.
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   // ==========================================================================
   // Scenarios
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd(8'hA5, 16'h0200);
      rd(8'hA6, 16'h0001);
      rd(8'hA9, 16'h0000);
      rd(8'h10, 16'h0000);
      wr(8'hA6, 16'h005A);
      rd(8'hA6, 16'h005A);
      fe.frame(8'h5A, 8'hFB, 4'h3);
      chk1("slm", 1'b0, label_mismatch_alarm);
      rd(8'hA7, 16'h005A);
      rd(8'hA8, 16'h000B);
      wr(8'hA7, 16'h00FF);
      rd(8'hA7, 16'h005A);
      fe.frame(8'h33, 8'h00, 4'h4);
      chk1("slm", 1'b1, label_mismatch_alarm);
      chk1("ais", 1'b0, path_ais_generated_status);
      wr(8'hA5, 16'h0210);
      chk1("ais", 1'b1, path_ais_generated_status);
      wr(8'hA6, 16'h0000);
      fe.frame(8'h00, 8'h00, 4'h0);
      chk1("uneq", 1'b1, unequipped_alarm);
      chk1("ais", 1'b0, path_ais_generated_status);
      wr(8'hA5, 16'h0208);
      chk1("ais", 1'b1, path_ais_generated_status);
      wr(8'hA5, 16'h0220);
      chk1("ais", 1'b1, path_ais_generated_status);
      wr(8'hA5, 16'h0200);
      chk1("ais", 1'b0, path_ais_generated_status);
      wr(8'hA9, 16'h0000);
      rd(8'hA9, 16'h0007);
      fe.frame(8'h00, 8'h00, 4'h2);
      rd(8'hA9, 16'h0007);
      wr(8'hA9, 16'h0000);
      rd(8'hA9, 16'h0002);
      wr(8'hB0, 16'h0001);
      fe.frame(8'h00, 8'h00, 4'h5);
      fe.frame(8'h00, 8'h00, 4'h0);
      wr(8'hA9, 16'h0000);
      rd(8'hA9, 16'h0001);
      foreach (cfgs[s]) begin
         wr(8'hA5, cfgs[s]);
         for (int i = 0; i < (cfgs[s][11] ? 5 : 3); i++) begin
            fe.msg(i > 0, 1'b0, 1'b1);
            chk1("unstable", cfgs[s][10:9] != 2'b01 && i < (cfgs[s][11] ? 4 : 2),
                 trace_unstable_alarm);
         end
         chk1("mismatch", cfgs[s][10:9] != 2'b01, trace_mismatch_alarm);
         chk1("ais", cfgs[s][10:9] != 2'b01, path_ais_generated_status);
      end
      wr(8'hA5, 16'h1704);
      fe.msg(1'b0, 1'b1, 1'b1);
      chk1("mismatch", 1'b1, trace_mismatch_alarm);
      wr(8'hA5, 16'h2404);
      repeat (3) fe.msg(1'b1, 1'b0, 1'b0);
      chk1("crc", 1'b1, trace_crc_error_alarm);
      chk1("mismatch", 1'b0, trace_mismatch_alarm);
      wr(8'hA5, 16'h0404);
      fe.msg(1'b1, 1'b0, 1'b0);
      chk1("mismatch", 1'b1, trace_mismatch_alarm);
      wr(8'hB2, 16'h003F);
      wr(8'hB3, 16'h0010);
      chk1("irq", 1'b0, irq);
      fe.frame(8'h01, 8'h00, 4'h0);
      fe.frame(8'h00, 8'h00, 4'h0);
      chk1("irq", 1'b1, irq);
      rd(8'hB2, 16'h0018);
      wr(8'hB3, 16'h0000);
      chk1("irq", 1'b0, irq);
      wr(8'hB3, 16'h0010);
      wr(8'hB2, 16'h0010);
      chk1("irq", 1'b0, irq);
      rd(8'hB2, 16'h0008);
      rd(8'hB1, 16'h0033);
      tally_and_finish();
   end
endmodule

// *** hdl/hopm_pkg.sv ***
// Package of register offsets, field positions, reset values and modes for the path monitor.
package hopm_pkg;

   // ==========================================================================
   // Register offsets (word addresses on the register port).
   localparam logic [7:0] OFS_CONFIG_TWO   = 8'hA5;
   localparam logic [7:0] OFS_EXP_LABEL    = 8'hA6;
   localparam logic [7:0] OFS_RCV_LABEL    = 8'hA7;
   localparam logic [7:0] OFS_G1_STATUS    = 8'hA8;
   localparam logic [7:0] OFS_PARITY_CNT   = 8'hA9;
   localparam logic [7:0] OFS_CONFIG_ONE   = 8'hB0;
   localparam logic [7:0] OFS_ALARM_STATUS = 8'hB1;
   localparam logic [7:0] OFS_IRQ_STATUS   = 8'hB2;
   localparam logic [7:0] OFS_IRQ_MASK     = 8'hB3;

   // ==========================================================================
   // Field positions of the second configuration register.
   localparam int BIT_CRC_MASK     = 13;
   localparam int BIT_UNSTABLE_FRC = 12;
   localparam int BIT_STABLE_SEL   = 11;
   localparam int POS_FORMAT_HI    = 10;
   localparam int POS_FORMAT_LO    = 8;
   localparam int BIT_AIS_FORCE    = 5;
   localparam int BIT_AIS_SLM      = 4;
   localparam int BIT_AIS_UNEQ     = 3;
   localparam int BIT_AIS_TIM      = 2;
   localparam logic [15:0] CONFIG_TWO_WMASK = 16'h3F3C;
   localparam logic [15:0] CONFIG_TWO_RESET = 16'h0200;

   // First configuration register: parity count mode in bit 0.
   localparam int BIT_PARITY_MODE = 0;

   // Alarm / event bit positions, shared by status, interrupt status and mask.
   localparam int EV_TIM      = 0;
   localparam int EV_CRC      = 1;
   localparam int EV_UNSTABLE = 2;
   localparam int EV_SLM      = 3;
   localparam int EV_UNEQ     = 4;
   localparam int EV_AIS      = 5;
   localparam int EV_WIDTH    = 6;

   localparam logic [7:0]  EXP_LABEL_RESET = 8'h01;
   localparam logic [15:0] COUNT_RESET     = 16'h0000;
   localparam logic [15:0] COUNT_MAX       = 16'hFFFF;
   localparam logic [2:0]  STABLE_RUN_LONG  = 3'h5;
   localparam logic [2:0]  STABLE_RUN_SHORT = 3'h3;

   // Trace format decode.
   typedef enum logic [2:0] {
      HOPM_FMT_SINGLE  = 3'b000,
      HOPM_FMT_IGNORE  = 3'b010,
      HOPM_FMT_CRC16   = 3'b100,
      HOPM_FMT_FREE64  = 3'b110,
      HOPM_FMT_FRAME64 = 3'b111
   } hopm_fmt_t;

endpackage

// *** hdl/hopm_top.sv ***
// Receive high-order path overhead monitor with register port and interrupt.
//
// Overview of operation
// R01 - With the CRC mask bit set, a CRC error hides the mismatch alarm unless forcing is on and the trace is unstable.
// R02 - With the unstable forcing bit set, an unstable trace forces the mismatch alarm active.
// R03 - The unstable alarm clears only after 5 (select 1) or 3 (select 0) identical consecutive trace messages; the 01X ignore format also clears it.
// R04 - The 3-bit format select chooses framed 64, free 64, 16 plus CRC-7, ignored, or single-byte traces.
// R05 - The AIS force bit drives downstream AIS unconditionally while set.
// R06 - With bit 4 set, a label mismatch (received C2 differs from expected) drives downstream AIS.
// R07 - With bit 3 set, an unequipped label (received C2 all zeros) drives downstream AIS.
// R08 - With bit 2 set, a trace mismatch alarm drives downstream AIS.
// R09 - An 8-bit writable expected label resets to 01H and is compared with the received C2.
// R10 - The received C2 byte reads back from a read-only 8-bit field.
// R11 - Received G1 bits 3 to 1 and bit 0 read back in bits 3 to 1 and bit 0.
// R12 - B3 parity errors accumulate in a 16-bit counter reset to zero, per the parity count mode.
// R13 - A write to the counter address moves the running count to a buffer and clears it; reads see the buffer.
// R14 - The C2 and G1 captures refresh once per frame from that frame's path overhead.
module hopm_top (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [15:0]      reg_rdata,
   // Path overhead of each received frame
   input  wire logic        frame_poh_valid,
   input  wire logic [7:0]  poh_c2,
   input  wire logic [7:0]  poh_g1,
   input  wire logic [3:0]  b3_error_bits,
   // Completed trace message from the trace framer
   input  wire logic        trace_msg_valid,
   input  wire logic        trace_msg_same,
   input  wire logic        trace_msg_match,
   input  wire logic        trace_msg_crc_ok,
   // Alarms and AIS toward adaptation
   output logic             trace_mismatch_alarm,
   output logic             trace_crc_error_alarm,
   output logic             trace_unstable_alarm,
   output logic             label_mismatch_alarm,
   output logic             unequipped_alarm,
   output logic             path_ais_generated_status,
   output logic             irq
);

   // ==========================================================================
   // Registers.
   logic [15:0] config_two_reg;
   logic        parity_count_mode_reg;
   logic [7:0]  expected_signal_label_reg;
   logic [7:0]  received_signal_label_reg;
   logic [2:0]  received_path_rdi_reg;
   logic        received_g1_spare_reg;
   logic [15:0] path_parity_error_count_reg;
   logic [15:0] parity_buffer_reg;
   logic [hopm_pkg::EV_WIDTH-1:0] irq_status_reg;
   logic [hopm_pkg::EV_WIDTH-1:0] irq_mask_reg;
   logic [hopm_pkg::EV_WIDTH-1:0] alarm_prev_reg;

   // ==========================================================================
   // Named configuration fields.
   wire mismatch_mask_on_crc_error = config_two_reg[hopm_pkg::BIT_CRC_MASK];
   wire mismatch_force_on_unstable = config_two_reg[hopm_pkg::BIT_UNSTABLE_FRC];
   wire trace_stable_count_sel     = config_two_reg[hopm_pkg::BIT_STABLE_SEL];
   wire [2:0] trace_format_sel     = config_two_reg[hopm_pkg::POS_FORMAT_HI:
                                                    hopm_pkg::POS_FORMAT_LO];
   wire path_ais_force             = config_two_reg[hopm_pkg::BIT_AIS_FORCE];
   wire ais_on_label_mismatch_en   = config_two_reg[hopm_pkg::BIT_AIS_SLM];
   wire ais_on_unequipped_en       = config_two_reg[hopm_pkg::BIT_AIS_UNEQ];
   wire ais_on_trace_mismatch_en   = config_two_reg[hopm_pkg::BIT_AIS_TIM];

   // ==========================================================================
   // Trace checking.
   logic raw_unstable;
   logic raw_mismatch;
   logic raw_crc;

   hopm_trace_check u_trace (
      .clk          (clk),
      .rst          (rst),
      .stable_sel   (trace_stable_count_sel),
      .format_sel   (trace_format_sel),
      .msg_valid    (trace_msg_valid),
      .msg_same     (trace_msg_same),
      .msg_match    (trace_msg_match),
      .msg_crc_ok   (trace_msg_crc_ok),
      .unstable     (raw_unstable),
      .raw_mismatch (raw_mismatch),
      .crc_error    (raw_crc)
   );

   wire crc_masks  = mismatch_mask_on_crc_error && raw_crc &&
                     (!mismatch_force_on_unstable || !raw_unstable);    // [R01]
   wire unst_force = mismatch_force_on_unstable && raw_unstable;         // [R02]
   wire tim_next   = unst_force || (raw_mismatch && !crc_masks);         // [R01] [R02]

   // ==========================================================================
   // Label alarms and AIS decision.
   wire slm_next  = (received_signal_label_reg != expected_signal_label_reg);   // [R09]
   wire uneq_next = (received_signal_label_reg == 8'h00);
   wire ais_next  = path_ais_force                                       // [R05]
                 || (ais_on_label_mismatch_en && slm_next)               // [R06]
                 || (ais_on_unequipped_en && uneq_next)                  // [R07]
                 || (ais_on_trace_mismatch_en && tim_next);              // [R08]

   wire [hopm_pkg::EV_WIDTH-1:0] alarm_vec = {ais_next, uneq_next, slm_next,
                                               raw_unstable, raw_crc, tim_next};
   wire [hopm_pkg::EV_WIDTH-1:0] alarm_rise = alarm_vec & ~alarm_prev_reg;

   // ==========================================================================
   // Register decode.
   wire wr_cfg2  = reg_wr && (reg_addr == hopm_pkg::OFS_CONFIG_TWO);
   wire wr_cfg1  = reg_wr && (reg_addr == hopm_pkg::OFS_CONFIG_ONE);
   wire wr_exp   = reg_wr && (reg_addr == hopm_pkg::OFS_EXP_LABEL);
   wire wr_cnt   = reg_wr && (reg_addr == hopm_pkg::OFS_PARITY_CNT);
   wire wr_istat = reg_wr && (reg_addr == hopm_pkg::OFS_IRQ_STATUS);
   wire wr_imask = reg_wr && (reg_addr == hopm_pkg::OFS_IRQ_MASK);

   function automatic logic [15:0] pad_ev(input logic [hopm_pkg::EV_WIDTH-1:0] v);
      pad_ev = {{(16 - hopm_pkg::EV_WIDTH){1'b0}}, v};
   endfunction

   logic [15:0] rd_mux;
   always_comb begin
      if (reg_addr == hopm_pkg::OFS_CONFIG_TWO) begin
         rd_mux = config_two_reg;
      end else if (reg_addr == hopm_pkg::OFS_EXP_LABEL) begin
         rd_mux = {8'h00, expected_signal_label_reg};
      end else if (reg_addr == hopm_pkg::OFS_RCV_LABEL) begin
         rd_mux = {8'h00, received_signal_label_reg};                    // [R10]
      end else if (reg_addr == hopm_pkg::OFS_G1_STATUS) begin
         rd_mux = {12'h000, received_path_rdi_reg, received_g1_spare_reg}; // [R11]
      end else if (reg_addr == hopm_pkg::OFS_PARITY_CNT) begin
         rd_mux = parity_buffer_reg;                                     // [R13]
      end else if (reg_addr == hopm_pkg::OFS_CONFIG_ONE) begin
         rd_mux = {15'h0000, parity_count_mode_reg};
      end else if (reg_addr == hopm_pkg::OFS_ALARM_STATUS) begin
         rd_mux = pad_ev(alarm_prev_reg);
      end else if (reg_addr == hopm_pkg::OFS_IRQ_STATUS) begin
         rd_mux = pad_ev(irq_status_reg);
      end else if (reg_addr == hopm_pkg::OFS_IRQ_MASK) begin
         rd_mux = pad_ev(irq_mask_reg);
      end else begin
         rd_mux = 16'h0000;
      end
   end

   // ==========================================================================
   // Parity counter: bit mode adds the error bits, block mode adds one per errored frame.
   wire [15:0] b3_inc = parity_count_mode_reg ? {15'h0000, (b3_error_bits != 4'h0)}
                                              : {12'h000, b3_error_bits};
   wire [16:0] b3_sum = {1'b0, path_parity_error_count_reg} + {1'b0, b3_inc};
   // Saturating so a slow poll never wraps back to a small count.
   wire [15:0] b3_next = b3_sum[16] ? hopm_pkg::COUNT_MAX : b3_sum[15:0];

   // ==========================================================================
   // Configuration and label registers.
   always_ff @(posedge clk) begin
      if (rst) begin
         config_two_reg            <= hopm_pkg::CONFIG_TWO_RESET;
         parity_count_mode_reg     <= 1'b0;
         expected_signal_label_reg <= hopm_pkg::EXP_LABEL_RESET;         // [R09]
         irq_mask_reg              <= '0;
      end else begin
         if (wr_cfg2) begin
            config_two_reg <= reg_wdata & hopm_pkg::CONFIG_TWO_WMASK;
         end
         if (wr_cfg1) begin
            parity_count_mode_reg <= reg_wdata[hopm_pkg::BIT_PARITY_MODE];
         end
         if (wr_exp) begin
            expected_signal_label_reg <= reg_wdata[7:0];                 // [R09]
         end
         if (wr_imask) begin
            irq_mask_reg <= reg_wdata[hopm_pkg::EV_WIDTH-1:0];
         end
      end
   end

   // Captured overhead has no reset value, as the received fields are undefined until a frame.
   always_ff @(posedge clk) begin
      if (frame_poh_valid) begin
         received_signal_label_reg <= poh_c2;                            // [R14] [R10]
         received_path_rdi_reg     <= poh_g1[3:1];                       // [R11]
         received_g1_spare_reg     <= poh_g1[0];                         // [R11]
      end
   end

   // ==========================================================================
   // Counter with latch-and-clear on write.
   always_ff @(posedge clk) begin
      if (rst) begin
         path_parity_error_count_reg <= hopm_pkg::COUNT_RESET;           // [R12]
         parity_buffer_reg           <= hopm_pkg::COUNT_RESET;
      end else if (wr_cnt) begin
         // The frame's errors arriving with the write go into the fresh count.
         parity_buffer_reg           <= path_parity_error_count_reg;     // [R13]
         path_parity_error_count_reg <= frame_poh_valid ? b3_inc : hopm_pkg::COUNT_RESET;
      end else if (frame_poh_valid) begin
         path_parity_error_count_reg <= b3_next;                         // [R12]
      end
   end

   // ==========================================================================
   // Alarm outputs, sticky interrupt status and read data.
   always_ff @(posedge clk) begin
      if (rst) begin
         alarm_prev_reg <= '0;
         irq_status_reg <= '0;
         irq            <= 1'b0;
         reg_rdata      <= 16'h0000;
      end else begin
         alarm_prev_reg <= alarm_vec;
         // A new rise wins over a write-one clear in the same cycle.
         irq_status_reg <= (irq_status_reg &
                            ~(wr_istat ? reg_wdata[hopm_pkg::EV_WIDTH-1:0] : '0))
                           | alarm_rise;
         irq            <= |(((irq_status_reg &
                            ~(wr_istat ? reg_wdata[hopm_pkg::EV_WIDTH-1:0] : '0))
                           | alarm_rise) & irq_mask_reg);
         reg_rdata      <= reg_rd ? rd_mux : 16'h0000;
      end
   end

   assign trace_mismatch_alarm      = alarm_prev_reg[hopm_pkg::EV_TIM];
   assign trace_crc_error_alarm     = alarm_prev_reg[hopm_pkg::EV_CRC];
   assign trace_unstable_alarm      = alarm_prev_reg[hopm_pkg::EV_UNSTABLE];
   assign label_mismatch_alarm      = alarm_prev_reg[hopm_pkg::EV_SLM];
   assign unequipped_alarm          = alarm_prev_reg[hopm_pkg::EV_UNEQ];
   assign path_ais_generated_status = alarm_prev_reg[hopm_pkg::EV_AIS];

endmodule

// *** hdl/hopm_trace_check.sv ***
// Trace stability and mismatch checker for received trace messages.
module hopm_trace_check (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Configuration
   input  wire logic       stable_sel,
   input  wire logic [2:0] format_sel,
   // Completed trace message from the trace framer
   input  wire logic       msg_valid,
   input  wire logic       msg_same,
   input  wire logic       msg_match,
   input  wire logic       msg_crc_ok,
   // Raw alarms
   output logic            unstable,
   output logic            raw_mismatch,
   output logic            crc_error
);

   logic [2:0] run_reg;
   logic [2:0] run_next;
   logic [2:0] run_need;
   logic       ignore;
   logic       has_crc;

   // ==========================================================================
   // Format interpretation: 01X ignores the trace, 10X carries CRC-7.
   assign ignore   = (format_sel[2:1] == 2'b01);                        // [R04]
   assign has_crc  = (format_sel[2:1] == 2'b10);                        // [R04]
   assign run_need = stable_sel ? hopm_pkg::STABLE_RUN_LONG
                                : hopm_pkg::STABLE_RUN_SHORT;           // [R03]
   assign run_next = !msg_same ? 3'h1 : (run_reg >= run_need) ? run_reg : run_reg + 3'h1;

   // ==========================================================================
   always_ff @(posedge clk) begin
      if (rst || ignore) begin
         run_reg      <= 3'h0;
         unstable     <= 1'b0;
         raw_mismatch <= 1'b0;
         crc_error    <= 1'b0;
      end else if (msg_valid) begin
         run_reg      <= run_next;
         unstable     <= (run_next < run_need);                         // [R03]
         raw_mismatch <= !msg_match;
         crc_error    <= has_crc && !msg_crc_ok;                        // [R04]
      end
   end

endmodule
